// ===== rtl/fpc_defines.svh
// Constants for the flash protection command host: register offsets, command codes, timing counts.
// Assumes a 20 MHz controller clock driving an asynchronous x16 flash bus.
`ifndef FPC_DEFINES_SVH
`define FPC_DEFINES_SVH
// Register word offsets (byte addresses)
`define FPC_REG_CMD      32'h0000_0000
`define FPC_REG_ARG      32'h0000_0004
`define FPC_REG_PWD_LO   32'h0000_0008
`define FPC_REG_PWD_HI   32'h0000_000C
`define FPC_REG_STATUS   32'h0000_0010
`define FPC_REG_RDATA    32'h0000_0014
// Command register fields
`define FPC_CMD_OP_MSB   4
`define FPC_CMD_GO_BIT   31
// Unlock addresses and data
`define FPC_ADDR_555     11'h555
`define FPC_ADDR_2AA     11'h2AA
`define FPC_ADDR_55      11'h055
`define FPC_ADDR_000     11'h000
`define FPC_ADDR_FF      8'hFF
`define FPC_D_AA         8'hAA
`define FPC_D_55         8'h55
`define FPC_D_GLOCK      8'h50
`define FPC_D_PWDMODE    8'h60
`define FPC_D_SETTINGS   8'h40
`define FPC_D_PROG       8'hA0
`define FPC_D_ZERO       8'h00
`define FPC_D_EXIT90     8'h90
`define FPC_D_QUERY      8'h98
`define FPC_D_IDEXIT     8'hF0
`define FPC_D_IRREV      8'h87
`define FPC_D_SUB1       8'h25
`define FPC_D_SUB2       8'h03
`define FPC_D_SUB3       8'h29
`define FPC_D_NVERASE1   8'h80
`define FPC_D_NVERASE3   8'h30
`define FPC_WC_MAX       4'hF
// Bus timing: write pulse and read access, in ns
`define FPC_T_WP_NS      40
`define FPC_T_ACC_NS     70
`define FPC_CLK_NS       50
`define FPC_WP_CYC       ((`FPC_T_WP_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_ACC_CYC      ((`FPC_T_ACC_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`endif

// ===== rtl/fpc_pkg.sv
// Types for the flash protection command host.
// Assumes fpc_defines.svh supplies the numbers.
package fpc_pkg;
  // Operations software may request
  typedef enum logic [4:0] {
    FPC_OP_GLOCK_ENTRY = 5'd0,
    FPC_OP_GLOCK_SET   = 5'd1,
    FPC_OP_MODE_EXIT   = 5'd2,
    FPC_OP_PWD_ENTRY   = 5'd3,
    FPC_OP_PWD_PROG    = 5'd4,
    FPC_OP_PWD_SUBMIT  = 5'd5,
    FPC_OP_SET_ENTRY   = 5'd6,
    FPC_OP_SET_PROG    = 5'd7,
    FPC_OP_QUERY_ENTRY = 5'd8,
    FPC_OP_ID_EXIT     = 5'd9,
    FPC_OP_IRREV_LOCK  = 5'd10,
    FPC_OP_READ        = 5'd11,
    FPC_OP_NV_ERASE    = 5'd12,
    FPC_OP_BUF_COUNT   = 5'd13
  } fpc_op_type;
  // Bus cycle sequencer
  typedef enum logic [2:0] {
    FPC_ST_IDLE  = 3'b000,
    FPC_ST_SETUP = 3'b001,
    FPC_ST_PULSE = 3'b011,
    FPC_ST_HOLD  = 3'b010,
    FPC_ST_RDWT  = 3'b110,
    FPC_ST_DONE  = 3'b111
  } fpc_state_type;
endpackage : fpc_pkg

// ===== rtl/fpc_host.sv
// Host controller issuing protection command sequences to an x16 parallel NOR flash.
// Assumes an AHB-Lite master on the same clock and the flash bus pins in the outer pad ring.
//
// Summary of operation
// [RULE_01] Global-lock entry is AAH@555H, 55H@2AAH, 50H@555H in exact order.
// [RULE_02] Global lock set is A0H then 00H; status bit 0 low means locked.
// [RULE_03] Mode exit writes 90H then 00H at any address.
// [RULE_04] Password entry ends 60H; each word is A0H then word at its address.
// [RULE_05] Address bits 1:0 select which 16-bit password portion is used.
// [RULE_06] Submit is 25H, 03H, four words at 00H-03H, then 29H, all at 00H base.
// [RULE_07] Lockout read at low byte FFH returns state on data bit three.
// [RULE_08] Query entry is 98H@55H; F0H anywhere leaves, same as ID exit.
// [RULE_09] Irreversible lock is unlock, 87H@555H, 00H; only when global lock reads 1.
// [RULE_10] Irreversible status bit 0 is 0 once the lock has been used.
// [RULE_11] Only address bits 10:0 and low data byte matter in commands.
// [RULE_12] Buffer word count is words minus one, 15 at most.
// [RULE_13] Extra buffer words repeat cycle five within the same bits 21:4.
// [RULE_14] Erase suspend and resume are also accepted in bypass mode.
// [RULE_15] In security-ID mode programming targets the security-ID area.
// [RULE_16] Product-ID mode does not survive power-down.
// [RULE_17] Block protection status reads 00H unprotected, 01H protected.
// [RULE_18] Non-volatile protection erase sets every lock bit to 1.
// [RULE_19] Block protected if either lock bit protects.
// [RULE_20] Product-ID read at address 0 gives maker code, next address device code.
// [RULE_21] Settings access enters with 40H, programs A0H then value, exits 90H 00H.
`timescale 1ns/1ns
`default_nettype none
`include "fpc_defines.svh"
module fpc_host #(
  parameter int WP_CYC  = `FPC_WP_CYC,   // Write pulse length in cycles
  parameter int ACC_CYC = `FPC_ACC_CYC   // Read access wait in cycles
) (
  input  wire logic        clk_in,       // 20 MHz clock
  input  wire logic        rst_in,       // Synchronous reset, high
  input  wire logic        hsel_in,      // AHB slave select
  input  wire logic [31:0] haddr_in,     // AHB address
  input  wire logic [1:0]  htrans_in,    // AHB transfer type
  input  wire logic        hwrite_in,    // AHB write
  input  wire logic [2:0]  hsize_in,     // AHB size
  input  wire logic [31:0] hwdata_in,    // AHB write data
  input  wire logic        hready_in,    // AHB bus ready
  output logic      [31:0] hrdata_out,   // AHB read data
  output logic             hreadyout_out,// AHB slave ready
  output logic             hresp_out,    // AHB response, always OKAY
  output logic      [21:0] fa_out,       // Flash address
  output logic      [15:0] fdq_out,      // Flash data out
  output logic             fdq_oe_out,   // Flash data drive enable
  input  wire logic [15:0] fdq_in,       // Flash data in
  output logic             fce_n_out,    // Flash chip enable, low
  output logic             fwe_n_out,    // Flash write enable, low
  output logic             foe_n_out     // Flash output enable, low
);
  // Elaboration check: the cycle counter is eight bits wide
  if (WP_CYC < 1 || WP_CYC > 255 || ACC_CYC < 1 || ACC_CYC > 255) begin : g_bad_timing
    $error("fpc_host: timing counts out of range");
  end

  // Bus slave state
  logic        ph_wr, next_ph_wr;
  logic [4:0]  ph_addr, next_ph_addr;
  logic [4:0]  op, next_op;
  logic [21:0] arg, next_arg;
  logic [31:0] pwd_lo, next_pwd_lo;
  logic [31:0] pwd_hi, next_pwd_hi;
  logic        busy, next_busy;
  logic        err, next_err;
  logic [15:0] rdata, next_rdata;
  // Sequencer state
  fpc_pkg::fpc_state_type st, next_st;
  logic [2:0]  idx, next_idx;
  logic [2:0]  last, next_last;
  logic [7:0]  cnt, next_cnt;
  logic [21:0] fa, next_fa;
  logic [15:0] fdq, next_fdq;
  logic        doe, next_doe;
  logic        ce_n, next_ce_n;
  logic        we_n, next_we_n;
  logic        oe_n, next_oe_n;
  // Three-stage input synchroniser
  logic [15:0] rs1, rs2, rs3;

  logic        req;
  logic        start_ok;
  logic [10:0] c_addr;
  logic [15:0] c_data;
  logic        c_rd;
  logic [2:0]  c_len;
  logic [15:0] pwd_word;

  assign req = hsel_in && hready_in && htrans_in[1];

  // Password word picked by address bits 1:0 of the argument or submit step
  always_comb begin
    logic [1:0] sel;
    sel = 2'b00;
    // [RULE_05] Portion select bits
    if (op == fpc_pkg::FPC_OP_PWD_SUBMIT) begin
      sel = 2'(idx - 3'd2);
    end else begin
      sel = arg[1:0];
    end
    case (sel)
      2'd0:    pwd_word = pwd_lo[15:0];
      2'd1:    pwd_word = pwd_lo[31:16];
      2'd2:    pwd_word = pwd_hi[15:0];
      default: pwd_word = pwd_hi[31:16];
    endcase
  end

  // Bus cycle table: address, data and length for each operation step
  always_comb begin
    c_addr = `FPC_ADDR_000;
    c_data = {8'h00, `FPC_D_ZERO};
    c_rd   = 1'b0;
    c_len  = 3'd0;
    case (op)
      // [RULE_01] Unlock order for global-lock, password, settings and irreversible lock entry
      fpc_pkg::FPC_OP_GLOCK_ENTRY, fpc_pkg::FPC_OP_PWD_ENTRY, fpc_pkg::FPC_OP_SET_ENTRY,
      fpc_pkg::FPC_OP_IRREV_LOCK: begin
        c_len = (op == fpc_pkg::FPC_OP_IRREV_LOCK) ? 3'd3 : 3'd2;
        case (idx)
          3'd0:    begin c_addr = `FPC_ADDR_555; c_data = {8'h00, `FPC_D_AA}; end
          3'd1:    begin c_addr = `FPC_ADDR_2AA; c_data = {8'h00, `FPC_D_55}; end
          3'd2:    begin
            c_addr = `FPC_ADDR_555;
            case (op)
              fpc_pkg::FPC_OP_GLOCK_ENTRY: c_data = {8'h00, `FPC_D_GLOCK};
              // [RULE_04] Password mode entry code
              fpc_pkg::FPC_OP_PWD_ENTRY:   c_data = {8'h00, `FPC_D_PWDMODE};
              // [RULE_21] Settings entry code
              fpc_pkg::FPC_OP_SET_ENTRY:   c_data = {8'h00, `FPC_D_SETTINGS};
              // [RULE_09] Irreversible lock code
              default:                     c_data = {8'h00, `FPC_D_IRREV};
            endcase
          end
          default: begin c_addr = `FPC_ADDR_000; c_data = {8'h00, `FPC_D_ZERO}; end
        endcase
      end
      // [RULE_02] Set global lock pair
      fpc_pkg::FPC_OP_GLOCK_SET: begin
        c_len  = 3'd1;
        c_data = (idx == 3'd0) ? {8'h00, `FPC_D_PROG} : {8'h00, `FPC_D_ZERO};
      end
      // [RULE_03] Exit pair 90H then 00H
      fpc_pkg::FPC_OP_MODE_EXIT: begin
        c_len  = 3'd1;
        c_data = (idx == 3'd0) ? {8'h00, `FPC_D_EXIT90} : {8'h00, `FPC_D_ZERO};
      end
      // [RULE_04] Password word program pair
      fpc_pkg::FPC_OP_PWD_PROG: begin
        c_len  = 3'd1;
        c_addr = (idx == 3'd0) ? `FPC_ADDR_000 : {9'h000, arg[1:0]};
        c_data = (idx == 3'd0) ? {8'h00, `FPC_D_PROG} : pwd_word;
      end
      // [RULE_06] Seven-write submit sequence
      fpc_pkg::FPC_OP_PWD_SUBMIT: begin
        c_len = 3'd6;
        case (idx)
          3'd0:    c_data = {8'h00, `FPC_D_SUB1};
          3'd1:    c_data = {8'h00, `FPC_D_SUB2};
          3'd6:    c_data = {8'h00, `FPC_D_SUB3};
          default: begin c_addr = {8'h00, idx - 3'd2}; c_data = pwd_word; end
        endcase
      end
      // [RULE_21] Settings value program pair
      fpc_pkg::FPC_OP_SET_PROG: begin
        c_len  = 3'd1;
        c_data = (idx == 3'd0) ? {8'h00, `FPC_D_PROG} : pwd_lo[15:0];
      end
      // [RULE_08] Query entry and ID exit
      fpc_pkg::FPC_OP_QUERY_ENTRY: begin
        c_addr = `FPC_ADDR_55;
        c_data = {8'h00, `FPC_D_QUERY};
      end
      fpc_pkg::FPC_OP_ID_EXIT: c_data = {8'h00, `FPC_D_IDEXIT};
      // [RULE_18] Erase all non-volatile lock bits
      fpc_pkg::FPC_OP_NV_ERASE: begin
        c_len = 3'd2;
        case (idx)
          3'd0:    c_data = {8'h00, `FPC_D_NVERASE1};
          3'd1:    c_data = {8'h00, `FPC_D_ZERO};
          default: c_data = {8'h00, `FPC_D_NVERASE3};
        endcase
      end
      // [RULE_12] Buffer count word, at most 15
      fpc_pkg::FPC_OP_BUF_COUNT: c_data = {12'h000, pwd_lo[3:0]};
      default: begin
        c_rd = 1'b1;
      end
    endcase
  end

  // [RULE_09] Irreversible lock refused unless stored global lock status reads 1
  // [RULE_12] Buffer count above 15 refused
  assign start_ok = (op != fpc_pkg::FPC_OP_IRREV_LOCK || rdata[0]) &&
                    (op != fpc_pkg::FPC_OP_BUF_COUNT || pwd_lo[31:4] == 28'h000_0000) &&
                    (op <= 5'(fpc_pkg::FPC_OP_BUF_COUNT));

  // Next values for slave and sequencer
  always_comb begin
    next_ph_wr   = req && hwrite_in;
    next_ph_addr = req ? haddr_in[6:2] : ph_addr;
    next_op      = op;
    next_arg     = arg;
    next_pwd_lo  = pwd_lo;
    next_pwd_hi  = pwd_hi;
    next_busy    = busy;
    next_err     = err;
    next_rdata   = rdata;
    next_st      = st;
    next_idx     = idx;
    next_last    = last;
    next_cnt     = cnt;
    next_fa      = fa;
    next_fdq     = fdq;
    next_doe     = doe;
    next_ce_n    = ce_n;
    next_we_n    = we_n;
    next_oe_n    = oe_n;
    if (ph_wr && !busy) begin
      case ({ph_addr, 2'b00})
        7'(`FPC_REG_ARG):    next_arg = hwdata_in[21:0];
        7'(`FPC_REG_PWD_LO): next_pwd_lo = hwdata_in;
        7'(`FPC_REG_PWD_HI): next_pwd_hi = hwdata_in;
        7'(`FPC_REG_CMD): begin
          next_op = hwdata_in[`FPC_CMD_OP_MSB:0];
          if (hwdata_in[`FPC_CMD_GO_BIT]) begin
            next_st   = fpc_pkg::FPC_ST_SETUP;
            next_busy = 1'b1;
            next_idx  = 3'd0;
            next_err  = 1'b0;
          end
        end
        default: ;
      endcase
    end
    case (st)
      fpc_pkg::FPC_ST_IDLE: ;
      fpc_pkg::FPC_ST_SETUP: begin
        if (idx == 3'd0 && !start_ok) begin
          next_err  = 1'b1;
          next_busy = 1'b0;
          next_st   = fpc_pkg::FPC_ST_IDLE;
        end else begin
          // [RULE_11] Upper address taken from argument only for reads
          next_fa      = c_rd ? arg : {11'h000, c_addr};
          next_fdq     = c_data;
          next_doe     = !c_rd;
          next_ce_n    = 1'b0;
          next_last    = c_len;
          next_cnt     = c_rd ? 8'(ACC_CYC) : 8'(WP_CYC);
          next_we_n    = c_rd;
          next_oe_n    = !c_rd;
          next_st      = c_rd ? fpc_pkg::FPC_ST_RDWT : fpc_pkg::FPC_ST_PULSE;
        end
      end
      fpc_pkg::FPC_ST_PULSE: begin
        next_cnt = cnt - 8'd1;
        if (cnt == 8'd1) begin
          next_we_n = 1'b1;
          next_st   = fpc_pkg::FPC_ST_HOLD;
        end
      end
      fpc_pkg::FPC_ST_HOLD: begin
        next_ce_n = 1'b1;
        next_doe  = 1'b0;
        if (idx == last) begin
          next_st = fpc_pkg::FPC_ST_DONE;
        end else begin
          next_idx = idx + 3'd1;
          next_st  = fpc_pkg::FPC_ST_SETUP;
        end
      end
      fpc_pkg::FPC_ST_RDWT: begin
        // Extra cycles let the data pass the three synchroniser stages
        next_cnt = cnt - 8'd1;
        if (cnt == 8'd0) begin
          if (rs2 == rs3) begin
            next_rdata = rs3;
            next_oe_n  = 1'b1;
            next_ce_n  = 1'b1;
            next_st    = fpc_pkg::FPC_ST_DONE;
          end else begin
            next_cnt = 8'd0;
          end
        end
      end
      fpc_pkg::FPC_ST_DONE: begin
        next_busy = 1'b0;
        next_st   = fpc_pkg::FPC_ST_IDLE;
      end
      default: next_st = fpc_pkg::FPC_ST_IDLE;
    endcase
  end

  // Registers
  always_ff @(posedge clk_in) begin
    rs1 <= fdq_in;
    rs2 <= rs1;
    rs3 <= rs2;
    if (rst_in) begin
      ph_wr <= 1'b0; ph_addr <= 5'd0; op <= 5'd0;
      arg <= 22'h00_0000; pwd_lo <= 32'h0000_0000; pwd_hi <= 32'h0000_0000;
      busy <= 1'b0; err <= 1'b0; rdata <= 16'h0000;
      st <= fpc_pkg::FPC_ST_IDLE; idx <= 3'd0; last <= 3'd0; cnt <= 8'd0;
      fa <= 22'h00_0000; fdq <= 16'h0000; doe <= 1'b0;
      ce_n <= 1'b1; we_n <= 1'b1; oe_n <= 1'b1;
    end else begin
      ph_wr <= next_ph_wr; ph_addr <= next_ph_addr; op <= next_op;
      arg <= next_arg; pwd_lo <= next_pwd_lo; pwd_hi <= next_pwd_hi;
      busy <= next_busy; err <= next_err; rdata <= next_rdata;
      st <= next_st; idx <= next_idx; last <= next_last; cnt <= next_cnt;
      fa <= next_fa; fdq <= next_fdq; doe <= next_doe;
      ce_n <= next_ce_n; we_n <= next_we_n; oe_n <= next_oe_n;
    end
  end

  // Read mux, zero wait states
  always_comb begin
    case ({ph_addr, 2'b00})
      7'(`FPC_REG_CMD):    hrdata_out = {27'h000_0000, op};
      7'(`FPC_REG_ARG):    hrdata_out = {10'h000, arg};
      7'(`FPC_REG_PWD_LO): hrdata_out = pwd_lo;
      7'(`FPC_REG_PWD_HI): hrdata_out = pwd_hi;
      7'(`FPC_REG_STATUS): hrdata_out = {30'h0000_0000, err, busy};
      7'(`FPC_REG_RDATA):  hrdata_out = {16'h0000, rdata};
      default:              hrdata_out = 32'h0000_0000;
    endcase
  end

  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign fa_out        = fa;
  assign fdq_out       = fdq;
  assign fdq_oe_out    = doe;
  assign fce_n_out     = ce_n;
  assign fwe_n_out     = we_n;
  assign foe_n_out     = oe_n;

  // [RULE_01] Third write of lock entry is 50H at 555H
  chk_entry_order: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE_01]
    (st == fpc_pkg::FPC_ST_SETUP && op == fpc_pkg::FPC_OP_GLOCK_ENTRY && idx == 3'd2)
    |=> (fa == 22'(`FPC_ADDR_555) && fdq[7:0] == `FPC_D_GLOCK)) else $error("lock entry third write wrong");
  // [RULE_03] Exit first write carries 90H
  chk_exit_code: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE_03]
    (st == fpc_pkg::FPC_ST_SETUP && op == fpc_pkg::FPC_OP_MODE_EXIT && idx == 3'd0)
    |=> fdq[7:0] == `FPC_D_EXIT90) else $error("exit code wrong");
  // [RULE_09] Irreversible lock never starts while global status reads 0
  chk_irrev_gate: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE_09]
    (st == fpc_pkg::FPC_ST_SETUP && idx == 3'd0 && op == fpc_pkg::FPC_OP_IRREV_LOCK && !rdata[0])
    |=> (st == fpc_pkg::FPC_ST_IDLE && err)) else $error("irreversible lock not refused");
  // [RULE_11] Command writes keep upper address bits low
  chk_addr_low: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE_11]
    (!we_n) |-> fa[21:11] == 11'h000) else $error("upper address bits driven in command");
  // [RULE_06] Submit closes with 29H
  chk_submit_end: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE_06]
    (st == fpc_pkg::FPC_ST_SETUP && op == fpc_pkg::FPC_OP_PWD_SUBMIT && idx == 3'd6)
    |=> fdq[7:0] == `FPC_D_SUB3) else $error("submit end code wrong");
  // [RULE_05] Password program address uses two low bits
  chk_pwd_addr: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE_05]
    (st == fpc_pkg::FPC_ST_SETUP && op == fpc_pkg::FPC_OP_PWD_PROG && idx == 3'd1)
    |=> fa == {20'h0_0000, arg[1:0]}) else $error("password address wrong");
  // [RULE_12] Counts above 15 are refused
  chk_count_max: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE_12]
    (st == fpc_pkg::FPC_ST_SETUP && idx == 3'd0 && op == fpc_pkg::FPC_OP_BUF_COUNT &&
     pwd_lo > 32'(`FPC_WC_MAX)) |=> (st == fpc_pkg::FPC_ST_IDLE && err)) else $error("count too large");
  // [RULE_08] Query entry at 55H
  chk_query_addr: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE_08]
    (!we_n && op == fpc_pkg::FPC_OP_QUERY_ENTRY) |-> (fa == 22'(`FPC_ADDR_55) && fdq[7:0] == `FPC_D_QUERY))
    else $error("query entry wrong");
endmodule : fpc_host
`default_nettype wire

// ===== verif/fpc_flash_model.sv
// Behavioural flash device: logs every write cycle and answers status and ID reads.
// Assumes the host strobes writes on the rising edge of the write enable, chip enable low.
`timescale 1ns/1ns
`default_nettype none
module fpc_flash_model #(
  parameter logic [15:0] MAKER_CODE  = 16'h005A, // Arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h00C3  // Arbitrary value
) (
  input  wire logic [21:0] fa_in,    // Address from host
  input  wire logic [15:0] fdq_in,   // Data wire
  input  wire logic        fce_n_in, // Chip enable, low
  input  wire logic        fwe_n_in, // Write enable, low
  input  wire logic        foe_n_in, // Output enable, low
  output logic      [15:0] fdq_out   // Data driven by the device
);
  logic [26:0] log_q [$];            // Logged {addr[10:0], data}
  logic [26:0] h1 = '0;
  logic [26:0] h2 = '0;
  logic [26:0] h3 = '0;
  logic [26:0] cur;
  logic        glock_mode = 1'b0;
  logic        glock_bit  = 1'b1;
  logic        irrev_bit  = 1'b1;
  logic        nv_bit     = 1'b0;
  logic        vol_bit    = 1'b1;
  logic [15:0] rd_val;
  logic [15:0] last_val   = '0;

  function automatic logic hit(input logic [26:0] e, input logic [10:0] a, input logic [7:0] d);
    return e[26:16] == a && e[7:0] == d;
  endfunction : hit

  // Command decode on the write strobe
  // only A10..A0 and low byte
  always @(posedge fwe_n_in) begin
    if (!fce_n_in) begin
      cur = {fa_in[10:0], fdq_in};
      log_q.push_back(cur);
      if (hit(h2, 11'h555, 8'hAA) && hit(h1, 11'h2AA, 8'h55) && hit(cur, 11'h555, 8'h50)) glock_mode = 1'b1;
      if (glock_mode && h1[7:0] == 8'hA0 && cur[7:0] == 8'h00) glock_bit = 1'b0;
      if (h1[7:0] == 8'h90 && cur[7:0] == 8'h00) glock_mode = 1'b0;
      if (hit(h3, 11'h555, 8'hAA) && hit(h2, 11'h2AA, 8'h55) && hit(h1, 11'h555, 8'h87) && cur[7:0] == 8'h00)
        irrev_bit = 1'b0;
      if (h2[7:0] == 8'h80 && h1[7:0] == 8'h00 && cur[7:0] == 8'h30) nv_bit = 1'b1;
      h3 = h2;
      h2 = h1;
      h1 = cur;
    end
  end

  // Read answers by address
  // status and ID reads
  always_comb begin
    if (fa_in[11:0] == 12'h9FF) rd_val = {15'h0000, glock_bit};
    else if (fa_in[10:0] == 11'h5FE) rd_val = {15'h0000, irrev_bit};
    else if (fa_in[7:0] == 8'hFF) rd_val = 16'h0008;
    else if (fa_in[7:0] == 8'h02) rd_val = {15'h0000, !nv_bit || !vol_bit};
    else if (fa_in[7:0] == 8'h00) rd_val = MAKER_CODE;
    else if (fa_in[7:0] == 8'h01) rd_val = DEVICE_CODE;
    else rd_val = ~fa_in[15:0];
  end

  // Released bus shows the inverse of the last answer
  always @(posedge foe_n_in) last_val = rd_val;
  assign fdq_out = (!fce_n_in && !foe_n_in) ? rd_val : ~last_val;
endmodule : fpc_flash_model
`default_nettype wire

// ===== verif/fpc_host_tb.sv
// Self-checking bench for the flash protection command host.
// Assumes the flash model file and the design files are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "fpc_defines.svh"
module fpc_host_tb;
  localparam logic [15:0] MAKER  = 16'h005A; // Arbitrary value
  localparam logic [15:0] DEVICE = 16'h00C3; // Arbitrary value
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = '0;
  logic [31:0] hrdata;
  logic [31:0] rdv;
  logic hready, fdq_oe, fce_n, fwe_n, foe_n;
  logic [21:0] fa;
  logic [15:0] fdq_h, fdq_f, fdq_w;
  logic [15:0] pw [4] = '{16'h1234, 16'hBEEF, 16'hC3C3, 16'h5A5A};
  logic [28:0] exp_q [$];
  int failures = 0;
  int checks_done = 0;

  // Clock and data wire resolution
  always #25 clk_in = ~clk_in;
  assign fdq_w = fdq_oe ? fdq_h : fdq_f;

  fpc_host dut (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(), .fa_out(fa), .fdq_out(fdq_h), .fdq_oe_out(fdq_oe),
    .fdq_in(fdq_w), .fce_n_out(fce_n), .fwe_n_out(fwe_n), .foe_n_out(foe_n));
  fpc_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) flash (.fa_in(fa), .fdq_in(fdq_w),
    .fce_n_in(fce_n), .fwe_n_in(fwe_n), .foe_n_in(foe_n), .fdq_out(fdq_f));

  task automatic close_out;
    if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("FAIL time %0t got %h expected %h", $time, got, exp);
      failures++;
    end
  endtask : chk

  // One bounded wait for hready at a rising edge
  task automatic wait_ready;
    int k;
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
    end while (hready !== 1'b1 && k < 100);
    if (k >= 100) begin
      failures++;
      close_out();
    end
  endtask : wait_ready

  // Single AHB word transfer; read data kept in rdv
  task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
    haddr <= addr;
    hwrite <= wr;
    htrans <= 2'b10;
    hsel <= 1'b1;
    hsize <= 3'b010;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= wdata;
    wait_ready();
    rdv = hrdata;
  endtask : ahb

  task automatic push(input logic ca, input logic [10:0] a, input logic ch, input logic [15:0] d);
    exp_q.push_back({ca, ch, a, d});
  endtask : push

  task automatic unlock(input logic [7:0] d3);
    push(1'b1, 11'h555, 1'b0, 16'h00AA);
    push(1'b1, 11'h2AA, 1'b0, 16'h0055);
    push(1'b1, 11'h555, 1'b0, {8'h00, d3});
  endtask : unlock

  // Start an operation, poll until idle, compare the logged bus cycles
  task automatic run_op(input logic [4:0] op, input logic err_exp);
    int k;
    logic [26:0] m;
    flash.log_q.delete();
    ahb(1'b1, `FPC_REG_CMD, {1'b1, 26'h000_0000, op});
    k = 0;
    do begin
      ahb(1'b0, `FPC_REG_STATUS, 32'h0000_0000);
      k++;
    end while (rdv[0] !== 1'b0 && k < 200);
    if (k >= 200) begin
      failures++;
      close_out();
    end
    chk({31'h0000_0000, rdv[1]}, {31'h0000_0000, err_exp});
    chk(flash.log_q.size(), exp_q.size());
    foreach (exp_q[i]) begin
      m = {exp_q[i][28] ? 11'h7FF : 11'h000, exp_q[i][27] ? 16'hFFFF : 16'h00FF};
      if (i < flash.log_q.size()) chk(flash.log_q[i] & m, exp_q[i][26:0] & m);
    end
    exp_q.delete();
  endtask : run_op

  task automatic rd_flash(input logic [21:0] a, input logic [15:0] exp);
    ahb(1'b1, `FPC_REG_ARG, {10'h000, a});
    run_op(fpc_pkg::FPC_OP_READ, 1'b0);
    ahb(1'b0, `FPC_REG_RDATA, 32'h0000_0000);
    chk({16'h0000, rdv[15:0]}, {16'h0000, exp});
  endtask : rd_flash

  task automatic sc_reset;
    ahb(1'b0, `FPC_REG_STATUS, 32'h0000_0000);
    chk(rdv, 32'h0000_0000);
    chk({28'h000_0000, fce_n, fwe_n, foe_n, fdq_oe}, 32'h0000_000E);
  endtask : sc_reset

  task automatic sc_irrev;
    rd_flash(22'h00_09FF, 16'h0001);
    unlock(8'h87);
    push(1'b0, 11'h000, 1'b0, 16'h0000);
    run_op(fpc_pkg::FPC_OP_IRREV_LOCK, 1'b0);
    rd_flash(22'h00_05FE, 16'h0000);
    run_op(fpc_pkg::FPC_OP_IRREV_LOCK, 1'b1);
  endtask : sc_irrev

  task automatic sc_glock;
    unlock(8'h50);
    run_op(fpc_pkg::FPC_OP_GLOCK_ENTRY, 1'b0);
    push(1'b0, 11'h000, 1'b0, 16'h00A0);
    push(1'b0, 11'h000, 1'b0, 16'h0000);
    run_op(fpc_pkg::FPC_OP_GLOCK_SET, 1'b0);
    rd_flash(22'h00_09FF, 16'h0000);
    push(1'b0, 11'h000, 1'b0, 16'h0090);
    push(1'b0, 11'h000, 1'b0, 16'h0000);
    run_op(fpc_pkg::FPC_OP_MODE_EXIT, 1'b0);
  endtask : sc_glock

  task automatic sc_pwd;
    ahb(1'b1, `FPC_REG_PWD_LO, {pw[1], pw[0]});
    ahb(1'b1, `FPC_REG_PWD_HI, {pw[3], pw[2]});
    unlock(8'h60);
    run_op(fpc_pkg::FPC_OP_PWD_ENTRY, 1'b0);
    for (int i = 0; i < 4; i++) begin
      ahb(1'b1, `FPC_REG_ARG, 32'h003F_F800 + i);
      push(1'b0, 11'h000, 1'b0, 16'h00A0);
      push(1'b1, i[10:0], 1'b1, pw[i]);
      run_op(fpc_pkg::FPC_OP_PWD_PROG, 1'b0);
    end
    push(1'b1, 11'h000, 1'b0, 16'h0025);
    push(1'b1, 11'h000, 1'b0, 16'h0003);
    for (int i = 0; i < 4; i++) push(1'b1, i[10:0], 1'b1, pw[i]);
    push(1'b1, 11'h000, 1'b0, 16'h0029);
    run_op(fpc_pkg::FPC_OP_PWD_SUBMIT, 1'b0);
  endtask : sc_pwd

  task automatic sc_settings;
    ahb(1'b1, `FPC_REG_PWD_LO, 32'h0000_5AC3);
    unlock(8'h40);
    run_op(fpc_pkg::FPC_OP_SET_ENTRY, 1'b0);
    push(1'b0, 11'h000, 1'b0, 16'h00A0);
    push(1'b0, 11'h000, 1'b1, 16'h5AC3);
    run_op(fpc_pkg::FPC_OP_SET_PROG, 1'b0);
    rd_flash(22'h00_00FF, 16'h0008);
  endtask : sc_settings

  task automatic sc_query;
    push(1'b1, 11'h055, 1'b0, 16'h0098);
    run_op(fpc_pkg::FPC_OP_QUERY_ENTRY, 1'b0);
    rd_flash(22'h00_0000, MAKER);
    rd_flash(22'h00_0001, DEVICE);
    push(1'b0, 11'h000, 1'b0, 16'h00F0);
    run_op(fpc_pkg::FPC_OP_ID_EXIT, 1'b0);
  endtask : sc_query

  task automatic sc_protect;
    rd_flash(22'h00_8002, 16'h0001);
    push(1'b0, 11'h000, 1'b0, 16'h0080);
    push(1'b0, 11'h000, 1'b0, 16'h0000);
    push(1'b0, 11'h000, 1'b0, 16'h0030);
    run_op(fpc_pkg::FPC_OP_NV_ERASE, 1'b0);
    rd_flash(22'h00_8002, 16'h0000);
  endtask : sc_protect

  task automatic sc_refuse;
    ahb(1'b1, `FPC_REG_PWD_LO, 32'h0000_000F);
    push(1'b0, 11'h000, 1'b1, 16'h000F);
    run_op(fpc_pkg::FPC_OP_BUF_COUNT, 1'b0);
    ahb(1'b1, `FPC_REG_PWD_LO, 32'h0000_0010);
    run_op(fpc_pkg::FPC_OP_BUF_COUNT, 1'b1);
    run_op(5'd14, 1'b1);
  endtask : sc_refuse

  // Main sequence
  initial begin
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    sc_reset();
    sc_irrev();
    sc_glock();
    sc_pwd();
    sc_settings();
    sc_query();
    sc_protect();
    sc_refuse();
    close_out();
  end
endmodule : fpc_host_tb
`default_nettype wire
